// [rtl/gpio_bank_pkg.sv]
// package: register map, reset values and widths of the pin bank
package gpio_bank_pkg;

  // ==========================================================
  // widths
  localparam int unsigned PIN_COUNT  = 16;
  localparam int unsigned ADDR_WIDTH = 16;

  // ==========================================================
  // register byte offsets
  localparam logic [15:0] OFS_BANK_EVENT_ENABLE = 16'h8000;
  localparam logic [15:0] OFS_PIN_DIRECTION     = 16'h0010;
  localparam logic [15:0] OFS_OUTPUT_LATCH      = 16'h0014;
  localparam logic [15:0] OFS_OUTPUT_SET        = 16'h0018;
  localparam logic [15:0] OFS_OUTPUT_CLEAR      = 16'h001c;
  localparam logic [15:0] OFS_PIN_LEVEL         = 16'h0020;
  localparam logic [15:0] OFS_RISE_SET          = 16'h0024;
  localparam logic [15:0] OFS_RISE_CLEAR        = 16'h0028;
  localparam logic [15:0] OFS_FALL_SET          = 16'h002c;
  localparam logic [15:0] OFS_FALL_CLEAR        = 16'h0030;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned ENABLE_BIT         = 0;
  localparam logic [15:0] DIRECTION_RESET    = 16'hffff;
  localparam logic [15:0] LATCH_RESET        = 16'h0000;
  localparam logic [15:0] MASK_RESET         = 16'h0000;

  // ==========================================================
  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage : gpio_bank_pkg

// [rtl/gpio_bank_edge_events.sv]
// sixteen-pin general purpose bank with edge events, on an ahb-lite slave
// Notes on behaviour
// - direction bit 0 output, 1 input
// - set port write one drives latch high
// - clear port write one drives latch low
// - latch write loads all bits at once
// - zero bits in set/clear change nothing
// - input pins ignore latch changes
// - pin level register returns sampled pins
// - set/clear ports read back the latch
// - per-pin event on rise, fall or both
// - edges detected in the peripheral clock
// - input pin transitions trigger selected events
// - output latch changes trigger events too
// - mask pair: 00 off,01 fall,10 rise,11 both
// - edge masks reachable only through ports
// - rise set port write one sets mask
// - rise clear port write one clears mask
// - fall ports work the same way
// - rise ports read rise mask, fall likewise
// - bank enable bit 0 gates all events
// - no freezing during debug halt
// - all sixteen events offered to cpu and dma
// - all pins inputs after reset
// - latch reads stored value, not the pin
//
// Our own choice: the AHB-Lite interface to the registers.
module gpio_bank_edge_events
  import gpio_bank_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  input  wire logic            clk,
  input  wire logic            nrst,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  // pins, three signals each
  input  wire logic [PINS-1:0] general_pin_in,
  output logic      [PINS-1:0] general_pin_out,
  output logic      [PINS-1:0] general_pin_oe,
  // events to cpu interrupt controller and dma controller
  output logic      [PINS-1:0] pin_event_vector,
  output logic      [PINS-1:0] pin_event_dma
);

  // ==========================================================
  // bus address phase capture
  logic [15:0]     addr_ff,   nxt_addr;
  logic            wr_ff,     nxt_wr;
  logic            rd_ff,     nxt_rd;
  logic [31:0]     rdata_ff,  nxt_rdata;
  logic            take;

  // state registers
  logic [PINS-1:0] dir_ff,    nxt_dir;
  logic [PINS-1:0] latch_ff,  nxt_latch;
  logic [PINS-1:0] rise_ff,   nxt_rise;
  logic [PINS-1:0] fall_ff,   nxt_fall;
  logic            enable_ff, nxt_enable;
  logic [PINS-1:0] sync1_ff,  sync2_ff,  prev_ff;
  logic [PINS-1:0] event_ff,  nxt_event;
  logic [PINS-1:0] pin_level;
  logic [PINS-1:0] wdata;

  // slave is always ready with an okay answer, so no wait states
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = rdata_ff;
  assign wdata     = hwdata[PINS-1:0];

  // only whole-word transfers are expected; hsize is not checked
  assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  // ==========================================================
  // address phase next values
  always_comb begin
    nxt_addr = addr_ff;
    nxt_wr   = 1'b0;
    nxt_rd   = 1'b0;
    if (take) begin
      nxt_addr = {haddr[15:2], 2'b00};
      nxt_wr   = hwrite;
      nxt_rd   = !hwrite;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff <= 16'h0000;
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      wr_ff   <= nxt_wr;
      rd_ff   <= nxt_rd;
    end
  end

  // ==========================================================
  // register writes in the data phase
  always_comb begin
    nxt_dir    = dir_ff;
    nxt_latch  = latch_ff;
    nxt_rise   = rise_ff;
    nxt_fall   = fall_ff;
    nxt_enable = enable_ff;
    if (wr_ff) begin
      unique case (addr_ff)
        OFS_BANK_EVENT_ENABLE: nxt_enable = hwdata[ENABLE_BIT];
        OFS_PIN_DIRECTION:     nxt_dir    = wdata;
        OFS_OUTPUT_LATCH:      nxt_latch  = wdata;
        OFS_OUTPUT_SET:        nxt_latch  = latch_ff | wdata;
        OFS_OUTPUT_CLEAR:      nxt_latch  = latch_ff & ~wdata;
        OFS_RISE_SET:          nxt_rise   = rise_ff | wdata;
        OFS_RISE_CLEAR:        nxt_rise   = rise_ff & ~wdata;
        OFS_FALL_SET:          nxt_fall   = fall_ff | wdata;
        OFS_FALL_CLEAR:        nxt_fall   = fall_ff & ~wdata;
        default: ;                                                // unmapped or read-only
      endcase
    end
  end

  // reset: all inputs (drivers off), latch and masks clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dir_ff    <= DIRECTION_RESET[PINS-1:0];
      latch_ff  <= LATCH_RESET[PINS-1:0];
      rise_ff   <= MASK_RESET[PINS-1:0];
      fall_ff   <= MASK_RESET[PINS-1:0];
      enable_ff <= 1'b0;
    end else begin
      dir_ff    <= nxt_dir;
      latch_ff  <= nxt_latch;
      rise_ff   <= nxt_rise;
      fall_ff   <= nxt_fall;
      enable_ff <= nxt_enable;
    end
  end

  // ==========================================================
  // read data, registered at the address phase so it stands in the data phase
  // masks have no own address: they show only through their ports
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      unique case ({haddr[15:2], 2'b00})
        OFS_BANK_EVENT_ENABLE: nxt_rdata[ENABLE_BIT] = enable_ff;
        OFS_PIN_DIRECTION:     nxt_rdata[PINS-1:0]   = dir_ff;
        OFS_OUTPUT_LATCH:      nxt_rdata[PINS-1:0]   = latch_ff;
        OFS_OUTPUT_SET,
        OFS_OUTPUT_CLEAR:      nxt_rdata[PINS-1:0]   = latch_ff;
        OFS_PIN_LEVEL:         nxt_rdata[PINS-1:0]   = pin_level;
        OFS_RISE_SET,
        OFS_RISE_CLEAR:        nxt_rdata[PINS-1:0]   = rise_ff;
        OFS_FALL_SET,
        OFS_FALL_CLEAR:        nxt_rdata[PINS-1:0]   = fall_ff;
        default:               nxt_rdata             = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // pin drivers: latch only reaches pins set as outputs
  assign general_pin_out = latch_ff;
  assign general_pin_oe  = ~dir_ff;

  // ==========================================================
  // sampling and edge detection, all in clk; no halt input exists,
  // so debug halts cannot freeze anything
  // the pad sees our own drive, so output changes show as edges
  assign pin_level = sync2_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end else begin
      sync1_ff <= general_pin_in;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // per-pin edge select against the mask pair
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_edge
      always_comb begin
        // current vs previous sample: one cycle per edge
        nxt_event[g] = enable_ff &&
                       ((rise_ff[g] && sync2_ff[g] && !prev_ff[g]) ||
                        (fall_ff[g] && !sync2_ff[g] && prev_ff[g]));
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      event_ff <= '0;
    end else begin
      event_ff <= nxt_event;
    end
  end

  // same pulse offered to the cpu and the dma controller
  assign pin_event_vector = event_ff;
  assign pin_event_dma    = event_ff;

endmodule : gpio_bank_edge_events

// [verif/pin_board.sv]
// board model: drives the pads of input pins, loops driven pads back
module pin_board #(
  parameter int unsigned PINS = 16
) (
  input  wire logic [PINS-1:0] pin_out,
  input  wire logic [PINS-1:0] pin_oe,
  input  wire logic [PINS-1:0] board_drive,
  output logic      [PINS-1:0] pad
);
  timeunit 1ns;
  timeprecision 100ps;
  // a driven pad shows the bank's level, so output edges reach the detector
  assign pad = (pin_out & pin_oe) | (board_drive & ~pin_oe);
endmodule : pin_board

// [verif/gpio_bank_chk.sv]
// checker: bus-to-pin and pin-to-event relations of the pin bank
module gpio_bank_chk
  import gpio_bank_pkg::*;
#(
  parameter int unsigned PINS = PIN_COUNT
) (
  input wire logic            clk, nrst, hsel, hwrite, hready,
  input wire logic [1:0]      htrans,
  input wire logic [31:0]     haddr, hwdata,
  input wire logic [PINS-1:0] general_pin_in, general_pin_out, general_pin_oe,
  input wire logic [PINS-1:0] pin_event_vector, pin_event_dma
);
  // ======
  // write data phase tracker; offset kept from the address phase
  logic        ph_ff;
  logic [15:0] ofs_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_ff  <= 1'b0;
      ofs_ff <= 16'h0;
    end else begin
      ph_ff  <= hsel && hready && htrans[1] && hwrite;
      ofs_ff <= haddr[15:0];
    end
  end
  // ======
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // data phase of a write to one register
  sequence s_wr(logic [15:0] o);
    ph_ff && ofs_ff == o;
  endsequence
  a_dir_write: assert property (
    s_wr(OFS_PIN_DIRECTION) |=> general_pin_oe == ~$past(hwdata[PINS-1:0]))
    else $error("enables differ from direction");
  a_latch_write: assert property (
    s_wr(OFS_OUTPUT_LATCH) |=> general_pin_out == $past(hwdata[PINS-1:0]))
    else $error("latch write lost");
  a_set_port: assert property (
    s_wr(OFS_OUTPUT_SET) |=> general_pin_out == $past(general_pin_out | hwdata[PINS-1:0]))
    else $error("set port wrong");
  a_clear_port: assert property (
    s_wr(OFS_OUTPUT_CLEAR) |=> general_pin_out == $past(general_pin_out & ~hwdata[PINS-1:0]))
    else $error("clear port wrong");
  a_pins_hold: assert property (
    !ph_ff |=> $stable(general_pin_out) && $stable(general_pin_oe))
    else $error("pins moved without a write");
  a_dma_copy: assert property (
    pin_event_dma == pin_event_vector)
    else $error("dma events differ");
  a_event_pulse: assert property (
    (pin_event_vector & $past(pin_event_vector)) == '0)
    else $error("event longer than a cycle");
  // an event needs a pad change four edges earlier, through the synchroniser
  a_event_cause: assert property (
    (pin_event_vector & ~($past(general_pin_in, 3) ^ $past(general_pin_in, 4))) == '0)
    else $error("event without pad edge");
endmodule : gpio_bank_chk

bind gpio_bank_edge_events gpio_bank_chk #(.PINS(PINS)) gpio_bank_chk_inst (.*);

// [verif/gpio_bank_edge_events_tb_top.sv]
// testbench: register rows, edge events and a mid-run reset of the pin bank
module gpio_bank_edge_events_tb_top
  import gpio_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic w; logic [15:0] a; logic [31:0] d;} row_s;
  logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
  logic [15:0] drive = 16'h5a00;
  wire  [31:0] hrdata;
  wire  [15:0] pad, pin_out, pin_oe, ev_cpu, ev_dma;
  wire         hreadyout, hresp;
  wire         hready = hreadyout;
  int          bad_count = 0, checked = 0;
  // reads expect d, writes send d
  row_s rows [19] = '{'{1'b0, OFS_PIN_DIRECTION, 32'hffff},
    '{1'b0, OFS_BANK_EVENT_ENABLE, 32'h0}, '{1'b0, 16'h0004, 32'h0},
    '{1'b1, OFS_PIN_DIRECTION, 32'hff00}, '{1'b1, OFS_OUTPUT_LATCH, 32'h1234},
    '{1'b0, OFS_OUTPUT_SET, 32'h1234}, '{1'b1, OFS_OUTPUT_SET, 32'h0081},
    '{1'b1, OFS_OUTPUT_CLEAR, 32'h0014}, '{1'b0, OFS_OUTPUT_LATCH, 32'h12a1},
    '{1'b1, OFS_RISE_SET, 32'h05f0}, '{1'b1, OFS_RISE_CLEAR, 32'h0030},
    '{1'b0, OFS_RISE_CLEAR, 32'h05c0}, '{1'b1, OFS_FALL_SET, 32'h060f},
    '{1'b1, OFS_FALL_CLEAR, 32'h0003}, '{1'b0, OFS_FALL_SET, 32'h060c},
    '{1'b1, OFS_BANK_EVENT_ENABLE, 32'hffffffff},
    '{1'b0, OFS_BANK_EVENT_ENABLE, 32'h1}, '{1'b1, OFS_PIN_LEVEL, 32'hffff},
    '{1'b0, OFS_PIN_LEVEL, 32'h5aa1}};
  gpio_bank_edge_events gpio_bank_edge_events_inst (.clk, .nrst, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .general_pin_in(pad), .general_pin_out(pin_out), .general_pin_oe(pin_oe),
    .pin_event_vector(ev_cpu), .pin_event_dma(ev_dma));
  pin_board pin_board_inst (.pin_out, .pin_oe, .board_drive(drive), .pad);
  always #2.5 clk = ~clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // one single transfer; waits on hready, no cycle count assumed
  task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {16'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    cmp({31'h0, hresp}, {31'h0, HRESP_OKAY}); // every answer is okay, nothing refused
  endtask : xfer
  // events are one-cycle pulses, so every cycle of the window is looked at
  task automatic ev(input logic [15:0] exp);
    logic [15:0] seen;
    seen = 16'h0;
    repeat (8) begin
      @(posedge clk);
      seen |= ev_cpu;
      cmp({16'h0, ev_dma}, {16'h0, ev_cpu});
    end
    cmp({16'h0, seen}, {16'h0, exp});
  endtask : ev
  task automatic results;
    if (bad_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  initial begin
    repeat (4000) @(posedge clk);
    bad_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) cmp(q, rows[i].d);
    end
    // output pins 6 and 3 under rise-only and fall-only masks
    xfer(1'b1, OFS_OUTPUT_SET, 32'h48);
    ev(16'h0040);
    xfer(1'b1, OFS_OUTPUT_CLEAR, 32'h48);
    ev(16'h0008);
    // input pins 8..11 hold masks 10, 01, 11 and 00
    drive <= drive ^ 16'h0f00;
    ev(16'h0700);
    drive <= drive ^ 16'h0f00;
    ev(16'h0400);
    xfer(1'b1, OFS_BANK_EVENT_ENABLE, 32'h0);
    drive <= drive ^ 16'h0f00;
    ev(16'h0000);
    // latch write must not reach input pads; wait out the synchroniser
    xfer(1'b1, OFS_OUTPUT_LATCH, 32'hffff);
    repeat (3) @(posedge clk);
    xfer(1'b0, OFS_PIN_LEVEL, 32'h0);
    cmp(q, 32'h55ff);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    cmp({16'h0, pin_oe}, 32'h0);
    xfer(1'b0, OFS_PIN_DIRECTION, 32'h0);
    cmp(q, 32'hffff);
    results();
  end
endmodule : gpio_bank_edge_events_tb_top
